/* File: src/ebus_pkg.sv */
/*
  Shared constants, state encoding and register image of the external
  bus interface. Assumes one 100 MHz clock and that the main clock
  output runs at half of it.
*/
// Function
// - Nonmultiplexed address stays valid from first through fourth phase.
// - Suppress bit floats shared bus during address phase for its region.
// - Narrow variant always drives upper address copy in data phase.
// - Strap low at reset overrides both suppress bits.
// - Narrow suppressed: low lines data only, copy bus address phases 2-4.
// - Address bus leads shared bus address by half a main clock period.
// - Upper lane store low only when upper lane select and write low.
// - Lower lane store low only when address bit zero and write low.
// - Narrow variant byte store enable low on every byte write.
// - Store enables use the early address bus timing.
// - Read strobe low during every read; here peripheral block reads leave it high.
// - PSRAM only in lower region, with chip-select precharge period.
// - PSRAM mode is off after every reset; here psram_mode_on is a plain input that reset does not clear.
// - PSRAM mode issues periodic refresh pulses, no row address.
// - Refresh strobe replaces mid select 3 on the shared pin.
// - Refresh holds lower select high and leaves address bus unused.
// - Peripheral registers are one 256-byte block of 16-bit words.
// - Narrow byte write to peripheral block transfers full 16 bits.
package ebus_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int PCB_IDX_W = 7;
  localparam int PCB_BASE_W = 12;
  localparam int REFRESH_W = 9;
  localparam int WAIT_W = 2;
  localparam int PCB_BASE_LSB = 8;
  localparam int PCB_IDX_LSB = 1;
  localparam logic [1:0] PHASE_DIV = 2'h2;
  localparam logic [WAIT_W-1:0] REFRESH_PHASES = 2'h2;
  localparam logic [WAIT_W-1:0] PRECHARGE_PHASES = 2'h1;
  localparam logic STRAP_KEEP_LEVEL = 1'b0;
  localparam logic [REFRESH_W-1:0] REFRESH_RESET = 9'h000;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 20'h00000;
  localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] OE_ALL_OFF = 16'hffff;
  localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [BYTE_W-1:0] BYTE_OFF = 8'hff;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_T1 = 8'h02,
    ST_T2 = 8'h04,
    ST_T3 = 8'h08,
    ST_TW = 8'h10,
    ST_T4 = 8'h20,
    ST_PRE = 8'h40,
    ST_REFRESH_STROBE_N = 8'h80
  } bus_state_t;

  typedef struct packed {
    bus_state_t state;
    logic [WAIT_W-1:0] cnt;
    logic wr;
    logic byte_acc;
    logic upper_hit;
    logic lower_hit;
    logic mid3_hit;
    logic psram_acc;
    logic sup;
    logic [DATA_W-1:0] wdata;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] ad_out;
    logic [DATA_W-1:0] ad_oe_n;
    logic [BYTE_W-1:0] copy_out;
    logic copy_oe_n;
    logic rd_n;
    logic wr_n;
    logic lane_n;
    logic ust_n;
    logic lst_n;
    logic bst_n;
    logic ucs_n;
    logic lcs_n;
    logic pin3_n;
    logic [REFRESH_W-1:0] rcount;
    logic rpend;
    logic strap_done;
    logic keep;
    logic [DATA_W-1:0] rdata;
    logic done;
    logic pcb_we;
    logic pcb_re;
    logic [PCB_IDX_W-1:0] pcb_idx;
    logic [DATA_W-1:0] pcb_wdata;
  } bus_regs_t;
endpackage

/* File: src/phase_divider.sv */
/*
  Main clock output divider and phase timing.
  Assumes a single reference clock; the output is a plain register.
*/
`timescale 1ns/1ps
`default_nettype none
module phase_divider (
  input wire logic ref_clk,
  input wire logic rstn,
  output logic main_clock_out,
  output logic phase_last
);
  logic [1:0] div_reg;
  logic [1:0] div_next;
  logic clk_reg;
  logic clk_next;

  // ----------------------------------------
  // Divider
  // ----------------------------------------
  always_comb begin
    phase_last = (div_reg == ebus_pkg::PHASE_DIV - 2'h1);
    div_next = phase_last ? 2'h0 : div_reg + 2'h1;
    clk_next = (div_next == 2'h0);
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      div_reg <= 2'h0;
      clk_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      clk_reg <= clk_next;
    end
  end

  assign main_clock_out = clk_reg;
endmodule
`default_nettype wire

/* File: src/ebus_interface.sv */
/*
  External bus interface: phase sequencer, address and data bus drive,
  byte store enables, read strobe, PSRAM precharge and auto refresh,
  and the internal peripheral block port.
  Assumes requests synchronous to ref_clk, upper and lower region hits
  decoded here from plain configuration ports, mid 3 hit given per request.
*/
`timescale 1ns/1ps
`default_nettype none
module ebus_interface (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic narrow_variant,
  input wire logic mux_address_keep_strap,
  input wire logic [19:0] upper_region_start,
  input wire logic upper_region_suppress,
  input wire logic [19:0] lower_region_end,
  input wire logic lower_region_suppress,
  input wire logic psram_mode_on,
  input wire logic ready_ignore,
  input wire logic [1:0] wait_count,
  input wire logic [8:0] prescaler_refresh_ctl,
  input wire logic [11:0] peripheral_block_base,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic req_byte,
  input wire logic req_mid3_hit,
  input wire logic [19:0] req_addr,
  input wire logic [15:0] req_wdata,
  output logic resp_done,
  output logic [15:0] resp_rdata,
  input wire logic ext_ready,
  output logic main_clock_out,
  output logic [19:0] address_bus,
  input wire logic [15:0] ad_in,
  output logic [15:0] ad_out,
  output logic [15:0] ad_oe_n,
  output logic [7:0] upper_address_copy_bus,
  output logic upper_address_copy_oe_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic upper_lane_select_n,
  output logic upper_lane_store_n,
  output logic lower_lane_store_n,
  output logic byte_store_enable_n,
  output logic upper_memory_select_n,
  output logic lower_memory_select_n,
  output logic mid3_refresh_pin_n,
  output logic refresh_active,
  output logic pcb_write,
  output logic pcb_read,
  output logic [6:0] pcb_index,
  output logic [15:0] pcb_wdata,
  input wire logic [15:0] pcb_rdata
);
  ebus_pkg::bus_regs_t r_reg;
  ebus_pkg::bus_regs_t r_next;
  logic phase_last;
  logic upper_dec;
  logic lower_dec;
  logic pcb_dec;
  logic idle_free;
  logic take_ext;
  logic take_pcb;
  logic wait_done;
  logic second_half;
  logic drive_addr;
  logic lane_up_n;

  phase_divider u_div (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .main_clock_out(main_clock_out),
    .phase_last(phase_last)
  );

  // ----------------------------------------
  // Request decode
  // ----------------------------------------
  always_comb begin
    upper_dec = (req_addr >= upper_region_start);
    lower_dec = (req_addr <= lower_region_end) && !upper_dec;
    // Word index only; odd offsets are undefined for software anyway
    pcb_dec = (req_addr[ebus_pkg::ADDR_W-1:ebus_pkg::PCB_BASE_LSB] == peripheral_block_base);
    idle_free = (r_reg.state == ebus_pkg::ST_IDLE) && !r_reg.rpend && !r_reg.done;
    // External cycles start on a phase boundary, refresh first
    req_ready = idle_free && (pcb_dec || phase_last);
    take_ext = req_valid && req_ready && !pcb_dec;
    take_pcb = req_valid && req_ready && pcb_dec;
    wait_done = (r_reg.cnt == '0) && (ready_ignore || ext_ready);
  end

  // ----------------------------------------
  // Sequencer and drive
  // ----------------------------------------
  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    r_next.pcb_we = 1'b0;
    r_next.pcb_re = 1'b0;
    second_half = 1'b0;
    drive_addr = 1'b0;
    lane_up_n = 1'b1;

    // Strap caught on the first clock after reset release
    if (!r_reg.strap_done) begin
      r_next.strap_done = 1'b1;
      r_next.keep = (mux_address_keep_strap == ebus_pkg::STRAP_KEEP_LEVEL);
    end

    // Refresh interval; the new request beats a clear in the same cycle
    if (!psram_mode_on) begin
      r_next.rcount = prescaler_refresh_ctl;
      r_next.rpend = 1'b0;
    end else if (phase_last) begin
      if (r_reg.rcount == ebus_pkg::REFRESH_RESET) begin
        r_next.rcount = prescaler_refresh_ctl;
        r_next.rpend = 1'b1;
      end else begin
        r_next.rcount = r_reg.rcount - 9'h001;
      end
    end

    if (take_pcb) begin
      r_next.pcb_we = req_write;
      r_next.pcb_re = !req_write;
      r_next.pcb_idx = req_addr[ebus_pkg::PCB_IDX_W:ebus_pkg::PCB_IDX_LSB];
      // Byte writes carry the whole word into the register
      r_next.pcb_wdata = req_wdata;
    end
    if (r_reg.pcb_re) begin
      r_next.rdata = pcb_rdata;
      r_next.done = 1'b1;
    end
    if (r_reg.pcb_we) begin
      r_next.done = 1'b1;
    end

    if (phase_last) begin
      case (r_reg.state)
        ebus_pkg::ST_IDLE: begin
          if (r_reg.rpend && !r_next.rpend) begin
            r_next.state = ebus_pkg::ST_IDLE;
          end else if (r_reg.rpend) begin
            r_next.state = ebus_pkg::ST_REFRESH_STROBE_N;
            r_next.cnt = ebus_pkg::REFRESH_PHASES - 2'h1;
            if (!r_next.rpend || r_reg.rcount != ebus_pkg::REFRESH_RESET) begin
              r_next.rpend = 1'b0;
            end
          end else if (take_ext) begin
            r_next.state = ebus_pkg::ST_T1;
            r_next.addr = req_addr;
            r_next.wr = req_write;
            r_next.byte_acc = req_byte;
            r_next.wdata = req_wdata;
            r_next.upper_hit = upper_dec;
            r_next.lower_hit = lower_dec;
            r_next.mid3_hit = req_mid3_hit && !psram_mode_on;
            r_next.psram_acc = lower_dec && psram_mode_on;
            r_next.sup = !r_next.keep && ((upper_dec && upper_region_suppress)
              || (lower_dec && lower_region_suppress));
          end
        end
        ebus_pkg::ST_T1: begin
          r_next.state = ebus_pkg::ST_T2;
        end
        ebus_pkg::ST_T2: begin
          r_next.state = ebus_pkg::ST_T3;
          r_next.cnt = wait_count;
        end
        ebus_pkg::ST_T3, ebus_pkg::ST_TW: begin
          if (wait_done) begin
            r_next.state = ebus_pkg::ST_T4;
            if (!r_reg.wr) begin
              r_next.rdata = narrow_variant ? {ebus_pkg::BYTE_ZERO, ad_in[7:0]} : ad_in;
            end
          end else begin
            r_next.state = ebus_pkg::ST_TW;
            if (r_reg.cnt != '0) begin
              r_next.cnt = r_reg.cnt - 2'h1;
            end
          end
        end
        ebus_pkg::ST_T4: begin
          if (r_reg.psram_acc) begin
            r_next.state = ebus_pkg::ST_PRE;
            r_next.cnt = ebus_pkg::PRECHARGE_PHASES - 2'h1;
          end else begin
            r_next.state = ebus_pkg::ST_IDLE;
            r_next.done = 1'b1;
          end
        end
        ebus_pkg::ST_PRE: begin
          if (r_reg.cnt == '0) begin
            r_next.state = ebus_pkg::ST_IDLE;
            r_next.done = 1'b1;
          end else begin
            r_next.cnt = r_reg.cnt - 2'h1;
          end
        end
        ebus_pkg::ST_REFRESH_STROBE_N: begin
          if (r_reg.cnt == '0) begin
            r_next.state = ebus_pkg::ST_IDLE;
          end else begin
            r_next.cnt = r_reg.cnt - 2'h1;
          end
        end
        default: begin
          r_next.state = ebus_pkg::ST_IDLE;
        end
      endcase
    end else begin
      second_half = 1'b1;
    end

    // Pin values for the coming cycle
    r_next.ad_oe_n = ebus_pkg::OE_ALL_OFF;
    r_next.ad_out = ebus_pkg::DATA_RESET;
    r_next.copy_oe_n = 1'b1;
    r_next.copy_out = ebus_pkg::BYTE_ZERO;
    r_next.rd_n = 1'b1;
    r_next.wr_n = 1'b1;
    r_next.ucs_n = 1'b1;
    r_next.lcs_n = 1'b1;
    r_next.pin3_n = 1'b1;
    case (r_next.state)
      ebus_pkg::ST_T1: begin
        // Shared bus gets the address one half period after the A bus
        drive_addr = second_half && !r_next.sup;
        if (drive_addr) begin
          r_next.ad_out = r_next.addr[15:0];
          r_next.ad_oe_n = narrow_variant ? {ebus_pkg::BYTE_OFF, ebus_pkg::BYTE_ZERO}
            : ~ebus_pkg::OE_ALL_OFF;
          r_next.copy_out = r_next.addr[15:8];
          r_next.copy_oe_n = !narrow_variant;
        end
        r_next.ucs_n = !r_next.upper_hit;
        r_next.lcs_n = !r_next.lower_hit;
        r_next.pin3_n = !r_next.mid3_hit;
      end
      ebus_pkg::ST_T2, ebus_pkg::ST_T3, ebus_pkg::ST_TW, ebus_pkg::ST_T4: begin
        // Copy bus keeps the address through the data phases
        r_next.copy_out = r_next.addr[15:8];
        r_next.copy_oe_n = !narrow_variant;
        if (r_next.wr) begin
          r_next.ad_out = narrow_variant ? {ebus_pkg::BYTE_ZERO, r_next.wdata[7:0]}
            : r_next.wdata;
          r_next.ad_oe_n = narrow_variant ? {ebus_pkg::BYTE_OFF, ebus_pkg::BYTE_ZERO}
            : ~ebus_pkg::OE_ALL_OFF;
        end
        if (r_next.state != ebus_pkg::ST_T4) begin
          r_next.rd_n = r_next.wr;
          r_next.wr_n = !r_next.wr;
        end
        r_next.ucs_n = !r_next.upper_hit;
        // PSRAM select goes high in the last phase to start its precharge
        r_next.lcs_n = !r_next.lower_hit
          || (r_next.psram_acc && r_next.state == ebus_pkg::ST_T4);
        r_next.pin3_n = !r_next.mid3_hit;
      end
      ebus_pkg::ST_REFRESH_STROBE_N: begin
        // No row address; A bus left holding the last cycle's value
        r_next.pin3_n = 1'b0;
        r_next.lcs_n = 1'b1;
      end
      default: begin
      end
    endcase

    // Lane select and byte enables follow the registered address timing
    if (r_next.state != ebus_pkg::ST_IDLE && r_next.state != ebus_pkg::ST_REFRESH_STROBE_N
        && r_next.state != ebus_pkg::ST_PRE && !narrow_variant) begin
      lane_up_n = r_next.byte_acc && !r_next.addr[0];
    end
    r_next.lane_n = lane_up_n;
    r_next.ust_n = narrow_variant || lane_up_n || r_next.wr_n;
    r_next.lst_n = narrow_variant || r_next.addr[0] || r_next.wr_n;
    r_next.bst_n = !narrow_variant || r_next.wr_n;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      r_reg <= '0;
      r_reg.state <= ebus_pkg::ST_IDLE;
      r_reg.addr <= ebus_pkg::ADDR_RESET;
      r_reg.ad_oe_n <= ebus_pkg::OE_ALL_OFF;
      r_reg.copy_oe_n <= 1'b1;
      r_reg.rd_n <= 1'b1;
      r_reg.wr_n <= 1'b1;
      r_reg.lane_n <= 1'b1;
      r_reg.ust_n <= 1'b1;
      r_reg.lst_n <= 1'b1;
      r_reg.bst_n <= 1'b1;
      r_reg.ucs_n <= 1'b1;
      r_reg.lcs_n <= 1'b1;
      r_reg.pin3_n <= 1'b1;
      r_reg.rcount <= ebus_pkg::REFRESH_RESET;
      r_reg.rpend <= 1'b0;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign resp_done = r_reg.done;
  assign resp_rdata = r_reg.rdata;
  assign address_bus = r_reg.addr;
  assign ad_out = r_reg.ad_out;
  assign ad_oe_n = r_reg.ad_oe_n;
  assign upper_address_copy_bus = r_reg.copy_out;
  assign upper_address_copy_oe_n = r_reg.copy_oe_n;
  assign read_strobe_n = r_reg.rd_n;
  assign write_strobe_n = r_reg.wr_n;
  assign upper_lane_select_n = r_reg.lane_n;
  assign upper_lane_store_n = r_reg.ust_n;
  assign lower_lane_store_n = r_reg.lst_n;
  assign byte_store_enable_n = r_reg.bst_n;
  assign upper_memory_select_n = r_reg.ucs_n;
  assign lower_memory_select_n = r_reg.lcs_n;
  assign mid3_refresh_pin_n = r_reg.pin3_n;
  assign refresh_active = (r_reg.state == ebus_pkg::ST_REFRESH_STROBE_N);
  assign pcb_write = r_reg.pcb_we;
  assign pcb_read = r_reg.pcb_re;
  assign pcb_index = r_reg.pcb_idx;
  assign pcb_wdata = r_reg.pcb_wdata;
endmodule
`default_nettype wire

/* File: testbench/ebus_monitor.sv */
/*
  Concurrent checks on the ports of the external bus interface.
  Assumes a bind to ebus_interface, one clock, asynchronous low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module ebus_monitor (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic narrow_variant,
  input wire logic psram_mode_on,
  input wire logic [19:0] address_bus,
  input wire logic [15:0] ad_out,
  input wire logic [15:0] ad_oe_n,
  input wire logic [7:0] upper_address_copy_bus,
  input wire logic upper_address_copy_oe_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic upper_lane_select_n,
  input wire logic upper_lane_store_n,
  input wire logic lower_lane_store_n,
  input wire logic byte_store_enable_n,
  input wire logic lower_memory_select_n,
  input wire logic mid3_refresh_pin_n,
  input wire logic refresh_active,
  input wire logic pcb_write,
  input wire logic pcb_read,
  input wire logic resp_done
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // ------------------------------------------------------------
  // Bus cycle checks
  // ------------------------------------------------------------
  addr_hold_a: assert property (!(read_strobe_n && write_strobe_n) |-> $stable(address_bus))
    else $error("address bus moved during strobe");
  addr_lead_a: assert property ($fell(ad_oe_n[0]) && write_strobe_n && read_strobe_n
    |-> ad_out[7:0] == address_bus[7:0] && $stable(address_bus))
    else $error("shared bus address not led by address bus");
  copy_drive_a: assert property (narrow_variant && !(read_strobe_n && write_strobe_n)
    |-> !upper_address_copy_oe_n && upper_address_copy_bus == address_bus[15:8])
    else $error("copy bus not driven in data phase");
  upper_store_a: assert property (!upper_lane_store_n |-> !write_strobe_n && !upper_lane_select_n)
    else $error("upper store without select and write");
  lower_store_a: assert property (!lower_lane_store_n |-> !write_strobe_n && !address_bus[0])
    else $error("lower store without bit zero and write");
  byte_store_a: assert property (narrow_variant && !byte_store_enable_n |-> !write_strobe_n)
    else $error("byte store outside a write");
  // ------------------------------------------------------------
  // Refresh and peripheral block
  // ------------------------------------------------------------
  refresh_quiet_a: assert property (refresh_active |-> lower_memory_select_n && $stable(address_bus))
    else $error("lower select or address moved in refresh");
  refresh_pulse_a: assert property ($fell(mid3_refresh_pin_n) && psram_mode_on
    |-> !mid3_refresh_pin_n [*4] ##1 mid3_refresh_pin_n)
    else $error("refresh pulse not four cycles");
  block_done_a: assert property (pcb_write || pcb_read |=> resp_done && !pcb_write && !pcb_read)
    else $error("peripheral access not closed next cycle");
endmodule
`default_nettype wire

/* File: testbench/ext_mem.sv */
/*
  Behavioural external memory on the shared bus.
  Assumes one word per even address, index from address bits 4..1.
*/
`timescale 1ns/1ps
`default_nettype none
module ext_mem (
  input wire logic ref_clk,
  input wire logic narrow_variant,
  input wire logic [19:0] address_bus,
  input wire logic [15:0] ad_out,
  input wire logic [15:0] ad_oe_n,
  input wire logic read_strobe_n,
  input wire logic upper_lane_store_n,
  input wire logic lower_lane_store_n,
  input wire logic byte_store_enable_n,
  output logic [15:0] ad_in,
  output logic ext_ready
);
  logic [15:0] mem [0:15];
  logic [15:0] last = 16'h0000;
  logic [15:0] drv;
  initial for (int i = 0; i < 16; i++) mem[i] = 16'h0000;
  // Released lines show the inverse of the last level, never a stale copy
  assign drv = !read_strobe_n ? mem[address_bus[4:1]] : ~last;
  assign ad_in = (~ad_oe_n & ad_out) | (ad_oe_n & drv);
  assign ext_ready = 1'b1;
  always @(posedge ref_clk) begin
    if (!narrow_variant && !upper_lane_store_n) mem[address_bus[4:1]][15:8] <= ad_out[15:8];
    if (!narrow_variant && !lower_lane_store_n) mem[address_bus[4:1]][7:0] <= ad_out[7:0];
    if (narrow_variant && !byte_store_enable_n) mem[address_bus[4:1]][7:0] <= ad_out[7:0];
    last <= ad_in;
  end
endmodule
`default_nettype wire

/* File: testbench/tb.sv */
/*
  Self-checking bench for the external bus interface.
  Assumes ext_mem on the far side and the checker bound below.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic ref_clk = 1'b0;
  logic rstn, narrow_variant, mux_address_keep_strap, upper_region_suppress;
  logic lower_region_suppress, psram_mode_on, ready_ignore, req_valid, req_ready;
  logic req_write, req_byte, req_mid3_hit, resp_done, ext_ready, main_clock_out;
  logic upper_address_copy_oe_n, read_strobe_n, write_strobe_n, upper_lane_select_n;
  logic upper_lane_store_n, lower_lane_store_n, byte_store_enable_n, upper_memory_select_n;
  logic lower_memory_select_n, mid3_refresh_pin_n, refresh_active, pcb_write, pcb_read;
  logic [19:0] upper_region_start, lower_region_end, req_addr, address_bus;
  logic [15:0] req_wdata, resp_rdata, ad_in, ad_out, ad_oe_n, pcb_wdata, pcb_rdata, oe2;
  logic [11:0] peripheral_block_base;
  logic [8:0] prescaler_refresh_ctl;
  logic [7:0] upper_address_copy_bus;
  logic [6:0] pcb_index;
  logic [1:0] wait_count;
  logic cp2, cp4, p1;
  int num_errors = 0;
  int compares = 0;
  int lat;
  ebus_interface ebus_interface_inst (.*);
  ext_mem ext_mem_inst (.*);
  always #5 ref_clk = ~ref_clk;
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task end_of_test;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input string nm, input logic [19:0] got, input logic [19:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task do_reset(input logic strap);
    @(negedge ref_clk);
    rstn = 1'b0;
    mux_address_keep_strap = strap;
    psram_mode_on = 1'b0;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    rstn = 1'b1;
    @(negedge ref_clk);
  endtask
  // Latency counts edges from the take edge, so refresh waits do not skew it
  task xfer(input logic w, input logic b, input logic [19:0] a, input logic [15:0] d);
    int k;
    @(negedge ref_clk);
    {req_write, req_byte, req_addr, req_wdata, req_valid} = {w, b, a, d, 1'b1};
    k = 0;
    while (req_ready !== 1'b1 && k < 300) begin
      @(negedge ref_clk);
      k++;
    end
    @(negedge ref_clk);
    req_valid = 1'b0;
    lat = 0;
    while (resp_done !== 1'b1 && lat < 300) begin
      // Block pulse stands in the first cycle, shared bus address in the second
      if (lat == 0) p1 = pcb_write | pcb_read;
      if (lat == 1) {oe2, cp2} = {ad_oe_n, upper_address_copy_oe_n};
      if (lat == 4) cp4 = upper_address_copy_oe_n;
      @(negedge ref_clk);
      lat++;
    end
    if (k == 300 || lat == 300) begin
      num_errors++;
      end_of_test;
    end
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task t_reset;
    do_reset(1'b1);
    chk("idle oe", {4'h0, ad_oe_n}, 20'h0ffff);
    chk("idle pins", {16'h0, write_strobe_n, read_strobe_n, lower_memory_select_n,
      mid3_refresh_pin_n}, 20'h0000f);
  endtask
  task t_wide;
    xfer(1'b1, 1'b0, 20'h00010, 16'h1234);
    chk("wr lat", 20'(lat), 20'h00008);
    chk("addr phase oe", {4'h0, oe2}, 20'h00000);
    xfer(1'b1, 1'b1, 20'h00013, 16'hab00);
    xfer(1'b0, 1'b0, 20'h00012, 16'h0000);
    chk("odd byte", {4'h0, resp_rdata}, 20'h0ab00);
    xfer(1'b0, 1'b0, 20'h00010, 16'h0000);
    chk("word rd", {4'h0, resp_rdata}, 20'h01234);
    chk("a bus hold", address_bus, 20'h00010);
  endtask
  task t_suppress;
    lower_region_suppress = 1'b1;
    xfer(1'b1, 1'b0, 20'h00020, 16'h0f0f);
    chk("lower float", {4'h0, oe2}, 20'h0ffff);
    {lower_region_suppress, upper_region_suppress} = 2'h1;
    xfer(1'b1, 1'b0, 20'hf0020, 16'h0f0f);
    chk("upper float", {4'h0, oe2}, 20'h0ffff);
    upper_region_suppress = 1'b0;
  endtask
  task t_strap;
    do_reset(1'b0);
    {lower_region_suppress, upper_region_suppress} = 2'h3;
    xfer(1'b1, 1'b0, 20'h00020, 16'h0f0f);
    chk("strap keeps addr", {4'h0, oe2}, 20'h00000);
    {lower_region_suppress, upper_region_suppress} = 2'h0;
    do_reset(1'b1);
  endtask
  task t_narrow;
    {narrow_variant, lower_region_suppress} = 2'h3;
    xfer(1'b1, 1'b1, 20'h00014, 16'h0055);
    chk("data only", {4'h0, oe2}, 20'h0ffff);
    chk("copy float t1", {19'h0, cp2}, 20'h00001);
    chk("copy data phase", {19'h0, cp4}, 20'h00000);
    xfer(1'b0, 1'b1, 20'h00014, 16'h0000);
    chk("byte rd", {4'h0, resp_rdata}, 20'h00055);
    {narrow_variant, lower_region_suppress} = 2'h0;
  endtask
  task t_pcb;
    narrow_variant = 1'b1;
    xfer(1'b1, 1'b1, 20'h0ff24, 16'hbeef);
    chk("blk lat", 20'(lat), 20'h00001);
    chk("blk pulse", {19'h0, p1}, 20'h00001);
    chk("blk index", {13'h0, pcb_index}, 20'h00012);
    chk("blk full word", {4'h0, pcb_wdata}, 20'h0beef);
    pcb_rdata = 16'h5a5a;
    xfer(1'b0, 1'b0, 20'h0ff24, 16'h0000);
    chk("blk rd", {4'h0, resp_rdata}, 20'h05a5a);
    narrow_variant = 1'b0;
  endtask
  task t_psram;
    int k;
    prescaler_refresh_ctl = 9'h012;
    {ready_ignore, wait_count} = 3'h5;
    psram_mode_on = 1'b1;
    xfer(1'b1, 1'b0, 20'h00010, 16'h4321);
    chk("psram lat", 20'(lat), 20'h0000c);
    k = 0;
    while (mid3_refresh_pin_n !== 1'b0 && k < 300) begin
      @(negedge ref_clk);
      k++;
    end
    chk("refresh pulse", {19'h0, mid3_refresh_pin_n}, 20'h00000);
    chk("refresh lower off", {19'h0, lower_memory_select_n}, 20'h00001);
    // Issued inside the refresh, so it must queue behind it
    xfer(1'b0, 1'b0, 20'h00010, 16'h0000);
    chk("after refresh", {4'h0, resp_rdata}, 20'h04321);
    chk("psram rd lat", 20'(lat), 20'h0000c);
    {psram_mode_on, wait_count} = 3'h0;
  endtask
  initial begin
    {rstn, narrow_variant, mux_address_keep_strap, upper_region_suppress} = 4'h1;
    {lower_region_suppress, psram_mode_on, ready_ignore, req_valid} = 4'h2;
    {req_write, req_byte, req_mid3_hit} = 3'h0;
    {upper_region_start, lower_region_end} = {20'hf0000, 20'h0ffff};
    {req_addr, req_wdata, pcb_rdata, wait_count} = '0;
    peripheral_block_base = 12'h0ff;
    prescaler_refresh_ctl = 9'h012;
    t_reset;
    t_wide;
    t_suppress;
    t_strap;
    t_narrow;
    t_pcb;
    t_psram;
    end_of_test;
  end
endmodule
bind ebus_interface ebus_monitor ebus_monitor_inst (.*);
`default_nettype wire
